//--- src/raster_fifo_pkg.sv
`default_nettype none

package raster_fifo_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite slave).
  localparam logic [7:0] raster_control_offset      = 8'h00;
  localparam logic [7:0] panel_dma_control_offset   = 8'h04;
  localparam logic [7:0] panel_status_register_off  = 8'h08;
  localparam logic [7:0] irq_status_offset          = 8'h0C;
  localparam logic [7:0] irq_enable_offset          = 8'h10;
  localparam logic [7:0] irq_clear_offset           = 8'h14;

  // ==========================================================================
  // Field positions.
  localparam int underflow_irq_enable_bit = 0;
  localparam int raster_enable_bit        = 1;
  localparam int fifo_underflow_flag_bit  = 0;
  localparam int fifo_ready_bit           = 1;
  localparam int level_lsb                = 16;
  localparam int threshold_lsb            = 0;
  localparam int threshold_width          = 10;

  // ==========================================================================
  // Reset values.
  localparam logic [9:0]  threshold_reset   = 10'h008;
  localparam logic [31:0] raster_ctrl_reset = 32'h0000_0000;

  // ==========================================================================
  // AXI response codes.
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // Pixel word as it leaves the raster path toward the pins.
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } pixel_word_s;

  // State of the raster output sequencer.
  typedef enum logic [1:0] {
    raster_idle,
    raster_wait_ready,
    raster_run
  } raster_state_e;

endpackage : raster_fifo_pkg

`default_nettype wire

//--- src/pixel_fifo.sv
`default_nettype none

module pixel_fifo #(
  parameter int width = 32,
  parameter int depth = 512,
  parameter int aw    = $clog2(depth)
) (
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             flush,
  // Fill side.
  input  wire logic             in_valid,
  input  wire logic [width-1:0] in_data,
  output logic                  in_ready,
  // Drain side.
  input  wire logic             out_pop,
  output logic [width-1:0]      out_data,
  output logic                  empty,
  output logic [aw:0]           level
);

  // ==========================================================================
  // Storage and pointers.
  logic [width-1:0] mem_q [depth];
  logic [aw-1:0]    wr_q;
  logic [aw-1:0]    rd_q;
  logic [aw:0]      cnt_q;

  // Handshake decode.
  wire push = in_valid && in_ready;
  wire pop  = out_pop && !empty;

  assign in_ready = ce && (cnt_q != (aw+1)'(depth));
  assign empty    = (cnt_q == '0);
  assign level    = cnt_q;
  assign out_data = mem_q[rd_q];

  // Pointer and count update; flush empties the FIFO for a controller reset.
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && flush)) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_q <= aw'(wr_q + 1'b1);
      if (pop) rd_q <= aw'(rd_q + 1'b1);
      cnt_q <= (aw+1)'(cnt_q + push - pop);
    end
  end

  // Data array has no reset so it maps onto block memory.
  always_ff @(posedge aclk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : pixel_fifo

`default_nettype wire

//--- src/axil_regs.sv
`default_nettype none

module axil_regs (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Register side: one-cycle write strobe and read mux input.
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);

  // ==========================================================================
  // Write channel: address and data are latched in either order.
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] awaddr_q;

  assign s_awready = ce && !aw_have_q && !s_bvalid;
  assign s_wready  = ce && !w_have_q && !s_bvalid;
  assign wr_en     = ce && aw_have_q && w_have_q && !s_bvalid;
  assign wr_addr   = awaddr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wr_data   <= '0;
      wr_strb   <= '0;
      s_bvalid  <= 1'b0;
      s_bresp   <= raster_fifo_pkg::resp_okay;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? raster_fifo_pkg::resp_okay : raster_fifo_pkg::resp_slverr;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read channel: answer one cycle after the address is taken.
  assign s_arready = ce && !s_rvalid;
  assign rd_addr   = s_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= raster_fifo_pkg::resp_okay;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        s_rresp  <= rd_ok ? raster_fifo_pkg::resp_okay : raster_fifo_pkg::resp_slverr;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule : axil_regs

`default_nettype wire

//--- src/raster_fifo_underflow.sv
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`default_nettype none

module raster_fifo_underflow #(
  parameter int depth = 512
) (
  // Clock, reset and clock enable.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Fill stream from the memory DMA path.
  input  wire logic        fill_valid,
  input  wire logic [31:0] fill_data,
  output logic             fill_ready,
  // Controller reset from the power/sleep controller.
  input  wire logic        local_power_sleep_ctrl_rst,
  // Pixel clock tick from the raster timing generator.
  input  wire logic        pixel_tick,
  // Panel data pins.
  output logic [31:0]      panel_data,
  output logic             panel_data_valid,
  // Interrupt.
  output logic             irq,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);

  localparam int aw = $clog2(depth);

  // ==========================================================================
  // Register state.
  logic        underflow_irq_enable_q;
  logic        raster_enable_q;
  logic [9:0]  fifo_ready_threshold_q;
  logic        fifo_underflow_flag_q;
  logic        irq_status_q;
  logic        irq_enable_q;
  logic        fifo_ready_q;
  logic [1:0]  rst_sync_q;
  logic        rst_meta_q;
  raster_fifo_pkg::raster_state_e state_q;
  raster_fifo_pkg::pixel_word_s   pix_q;

  // Bus-side wires.
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] fifo_word;
  logic        fifo_empty;
  logic [aw:0] fifo_level;

  // ==========================================================================
  // Synchronise the external controller reset (three stages, last two agree).
  // The first stage may go metastable, so only the later two are compared.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 2'b00;
    end else if (ce) begin
      rst_meta_q <= local_power_sleep_ctrl_rst;
      rst_sync_q <= {rst_sync_q[0], rst_meta_q};
    end
  end

  wire ctrl_rst = (rst_sync_q == 2'b11);

  // ==========================================================================
  // Address decode.
  // Writes to the read-only interrupt status are answered okay and ignored.
  wire wr_ctrl  = wr_en && (wr_addr == raster_fifo_pkg::raster_control_offset);
  wire wr_dma   = wr_en && (wr_addr == raster_fifo_pkg::panel_dma_control_offset);
  wire wr_stat  = wr_en && (wr_addr == raster_fifo_pkg::panel_status_register_off);
  wire wr_ien   = wr_en && (wr_addr == raster_fifo_pkg::irq_enable_offset);
  wire wr_iclr  = wr_en && (wr_addr == raster_fifo_pkg::irq_clear_offset);
  wire wr_known = wr_ctrl || wr_dma || wr_stat || wr_ien || wr_iclr
                  || (wr_addr == raster_fifo_pkg::irq_status_offset);
  wire rd_known = (rd_addr <= raster_fifo_pkg::irq_clear_offset) && (rd_addr[1:0] == 2'b00);

  // ==========================================================================
  // Raster fetch: the sequencer pops one word per pixel tick once running.
  // A tick outside the run state is ignored and never counts as an underflow.
  wire fetch     = ce && (state_q == raster_fifo_pkg::raster_run) && pixel_tick;
  wire underflow = fetch && fifo_empty;
  wire pop       = fetch && !fifo_empty;

  // Ready once the fill level reaches the programmed 32-bit word threshold.
  // A threshold above the FIFO depth is never met, so the raster never starts.
  wire level_ok = fifo_level >= (aw+1)'(fifo_ready_threshold_q);

  // Input FIFO; the controller reset flushes it so a restart begins empty.
  pixel_fifo #(
    .width (32),
    .depth (depth)
  ) u_fifo (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .flush    (ctrl_rst),
    .in_valid (fill_valid),
    .in_data  (fill_data),
    .in_ready (fill_ready),
    .out_pop  (pop),
    .out_data (fifo_word),
    .empty    (fifo_empty),
    .level    (fifo_level)
  );

  // ==========================================================================
  // Control registers; a controller reset returns them to defaults.
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && ctrl_rst)) begin
      underflow_irq_enable_q <= raster_fifo_pkg::raster_ctrl_reset[0];
      raster_enable_q        <= raster_fifo_pkg::raster_ctrl_reset[1];
      fifo_ready_threshold_q <= raster_fifo_pkg::threshold_reset;
      irq_enable_q           <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl && wr_strb[0]) begin
        underflow_irq_enable_q <= wr_data[raster_fifo_pkg::underflow_irq_enable_bit];
        raster_enable_q        <= wr_data[raster_fifo_pkg::raster_enable_bit];
      end
      if (wr_dma && wr_strb[0]) begin
        fifo_ready_threshold_q[7:0] <= wr_data[7:0];
      end
      if (wr_dma && wr_strb[1]) begin
        fifo_ready_threshold_q[9:8] <= wr_data[9:8];
      end
      if (wr_ien && wr_strb[0]) begin
        irq_enable_q <= wr_data[0];
      end
    end
  end

  // ==========================================================================
  // Write-one-to-clear decode, shared by the status flag and the interrupt clear.
  function automatic logic clear_hit(
    input logic        sel,
    input logic [3:0]  strb,
    input logic [31:0] data
  );
    return sel && strb[0] && data[0];
  endfunction : clear_hit

  // Only a write of one clears; a zero write leaves the flag for software.
  wire clr_flag = clear_hit(wr_stat, wr_strb, wr_data);
  wire clr_irq  = clear_hit(wr_iclr, wr_strb, wr_data);

  // Sticky flags: a new underflow wins over a clear in the same cycle, so
  // an event that lands on the clear write is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && ctrl_rst)) begin
      fifo_underflow_flag_q <= 1'b0;
      irq_status_q          <= 1'b0;
    end else if (ce) begin
      if (underflow) begin
        fifo_underflow_flag_q <= 1'b1;
      end else if (clr_flag) begin
        fifo_underflow_flag_q <= 1'b0;
      end
      if (underflow && underflow_irq_enable_q) begin
        irq_status_q <= 1'b1;
      end else if (clr_irq) begin
        irq_status_q <= 1'b0;
      end
    end
  end

  // Interrupt output is registered; stays high until software clears it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_status_q && irq_enable_q;
    end
  end

  // ==========================================================================
  // Raster sequencer: waits for the threshold before fetching, then runs.
  // The ready bit in the status register trails the fill level by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && ctrl_rst)) begin
      state_q      <= raster_fifo_pkg::raster_idle;
      fifo_ready_q <= 1'b0;
    end else if (ce) begin
      fifo_ready_q <= level_ok;
      case (state_q)
        raster_fifo_pkg::raster_idle: begin
          if (raster_enable_q) begin
            state_q <= raster_fifo_pkg::raster_wait_ready;
          end
        end
        raster_fifo_pkg::raster_wait_ready: begin
          if (!raster_enable_q) begin
            state_q <= raster_fifo_pkg::raster_idle;
          end else if (level_ok) begin
            state_q <= raster_fifo_pkg::raster_run;
          end
        end
        raster_fifo_pkg::raster_run: begin
          if (!raster_enable_q) begin
            state_q <= raster_fifo_pkg::raster_idle;
          end
        end
        default: begin
          state_q <= raster_fifo_pkg::raster_idle;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin driver: on underflow the stale word stays on the pins, marked invalid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_q <= '0;
    end else if (ce) begin
      if (pop) begin
        pix_q <= '{valid: 1'b1, data: fifo_word};
      end else if (underflow) begin
        pix_q.valid <= 1'b0;
      end
    end
  end

  assign panel_data       = pix_q.data;
  assign panel_data_valid = pix_q.valid;

  // ==========================================================================
  // Read words, one per register; the mux below only selects.
  wire [31:0] ctrl_word   = {30'h0, raster_enable_q, underflow_irq_enable_q};
  wire [31:0] dma_word    = {22'h0, fifo_ready_threshold_q};
  wire [31:0] status_word = {16'(fifo_level), 14'h0, fifo_ready_q, fifo_underflow_flag_q};
  wire [31:0] istat_word  = {31'h0, irq_status_q};
  wire [31:0] ien_word    = {31'h0, irq_enable_q};

  // Read mux; the write-only clear register reads as zero.
  wire [31:0] rd_mux =
      (rd_addr == raster_fifo_pkg::raster_control_offset)     ? ctrl_word   :
      (rd_addr == raster_fifo_pkg::panel_dma_control_offset)  ? dma_word    :
      (rd_addr == raster_fifo_pkg::panel_status_register_off) ? status_word :
      (rd_addr == raster_fifo_pkg::irq_status_offset)         ? istat_word  :
      (rd_addr == raster_fifo_pkg::irq_enable_offset)         ? ien_word    :
      32'h0000_0000;

  axil_regs u_regs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (wr_known),
    .rd_addr   (rd_addr),
    .rd_data   (rd_mux),
    .rd_ok     (rd_known)
  );

endmodule : raster_fifo_underflow

`default_nettype wire

//--- tb/raster_fifo_underflow_properties.sv
`default_nettype none

// ==========================================================
// Port-level checker: raster output, interrupt and bus rules.
module raster_fifo_underflow_properties #(
  parameter int depth = 512
) (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // Raster side.
  input wire logic        pixel_tick,
  input wire logic [31:0] panel_data,
  input wire logic        panel_data_valid,
  input wire logic        irq,
  // Bus handshakes.
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_word_after_tick;
    $rose(panel_data_valid) |-> $past(pixel_tick);
  endproperty
  a_word_after_tick: assert property (p_word_after_tick)
    else $error("valid word appeared without a fetch");
  property p_invalid_after_tick;
    $fell(panel_data_valid) |-> $past(pixel_tick);
  endproperty
  a_invalid_after_tick: assert property (p_invalid_after_tick)
    else $error("valid dropped without a fetch");
  // An interrupt edge is caused by an underflow fetch or a register write.
  property p_irq_cause;
    $rose(irq) |-> $past(pixel_tick, 2) || $past(s_bvalid) || $past(s_bvalid, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without a cause");
  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped early");
  property p_r_latency;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_r_latency: assert property (p_r_latency)
    else $error("read answer late");
  property p_b_latency;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:3] s_bvalid;
  endproperty
  a_b_latency: assert property (p_b_latency)
    else $error("write answer late");
  property p_one_outstanding;
    (s_bvalid |-> !s_awready && !s_wready) and (s_rvalid |-> !s_arready);
  endproperty
  a_one_outstanding: assert property (p_one_outstanding)
    else $error("request accepted while answer pending");
  property p_freeze;
    !ce |=> $stable(panel_data) && $stable(panel_data_valid) && $stable(irq);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while frozen");

  // Main scenarios seen.
  c_underflow: cover property ($fell(panel_data_valid));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_rvalid && s_rresp == raster_fifo_pkg::resp_slverr);
  c_frozen: cover property (!ce);
endmodule : raster_fifo_underflow_properties

bind raster_fifo_underflow raster_fifo_underflow_properties #(.depth(depth))
  raster_fifo_underflow_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .pixel_tick(pixel_tick),
  .panel_data(panel_data), .panel_data_valid(panel_data_valid), .irq(irq),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
  .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

`default_nettype wire

//--- tb/panel_model.sv
`default_nettype none

// ==========================================================
// Panel sink: latches one word per fetch, ignores invalid beats.
module panel_model (
  // Clock.
  input wire logic        aclk,
  // Pins.
  input wire logic        pixel_tick,
  input wire logic [31:0] panel_data,
  input wire logic        panel_data_valid,
  // Observed traffic.
  output var int          n_words,
  output logic [31:0]     last_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_q;
  int   count_q = 0;

  assign n_words = count_q;

  // A word is read one cycle after its fetch; garbage beats are dropped.
  always @(posedge aclk) begin
    tick_q <= pixel_tick;
    if (tick_q && panel_data_valid) begin
      count_q   <= count_q + 1;
      last_word <= panel_data;
    end
  end
endmodule : panel_model

`default_nettype wire

//--- tb/tb_raster_fifo_underflow.sv
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

// ==========================================================
// Bench: bus tasks, fill stream, pixel fetches.
module tb_raster_fifo_underflow;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, ce = 1, fill_valid = 0, fill_ready, rst_ctl = 0;
  logic pixel_tick = 0, panel_data_valid, irq;
  logic [31:0] fill_data = 32'h0000_0000, panel_data, s_wdata = 32'h0000_0000, s_rdata;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 0, s_awready, s_wvalid = 0, s_wready, s_bvalid, s_bready = 0;
  logic s_arvalid = 0, s_arready, s_rvalid, s_rready = 0;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [31:0] rd;
  logic [31:0] last_word;
  int n_errors = 0, samples_checked = 0, n_words;
  localparam logic [31:0] base = 32'hA5A5_0000;

  always #2.5 aclk = ~aclk;

  raster_fifo_underflow raster_fifo_underflow_inst (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .fill_valid(fill_valid), .fill_data(fill_data), .fill_ready(fill_ready),
    .local_power_sleep_ctrl_rst(rst_ctl), .pixel_tick(pixel_tick),
    .panel_data(panel_data), .panel_data_valid(panel_data_valid), .irq(irq),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  panel_model panel_model_inst (.aclk(aclk), .pixel_tick(pixel_tick),
    .panel_data(panel_data), .panel_data_valid(panel_data_valid),
    .n_words(n_words), .last_word(last_word));

  // ==========================================================
  // Bus tasks: each channel held until its own ready.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 0;
      if (s_wvalid && s_wready) s_wvalid <= 0;
    end while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata; resp = s_rresp;
    s_rready <= 0;
  endtask : axr
  // Streams n words from the memory path; valid stays up between words.
  task automatic fill(input int n, input int first);
    for (int i = 0; i < n; i++) begin
      fill_valid <= 1; fill_data <= base + 32'(first + i);
      do @(posedge aclk); while (fill_ready !== 1'b1);
    end
    fill_valid <= 0;
  endtask : fill
  // One fetch; the word is due right after the edge that takes the tick.
  task automatic tick(input logic v, input logic [31:0] d);
    @(posedge aclk);
    pixel_tick <= 1;
    @(posedge aclk);
    pixel_tick <= 0;
    #1;
    `CHK("valid", v, panel_data_valid)
    if (v) `CHK("pixel", d, panel_data)
  endtask : tick
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Watchdog sized well above the roughly 900 cycles of the sequence.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    axr(8'h04); `CHK("thr reset", 32'h0000_0008, rd)
    axr(8'h20); `CHK("unmapped resp", raster_fifo_pkg::resp_slverr, resp)
    `CHK("unmapped data", 32'h0000_0000, rd)
    axw(8'h21, 32'h0000_0001); `CHK("unaligned resp", raster_fifo_pkg::resp_slverr, resp)
    // Software raises the threshold before enabling the raster.
    axw(8'h04, 32'h0000_0100);
    axw(8'h10, 32'h0000_0001);
    axw(8'h00, 32'h0000_0003);
    fill(255, 0);
    repeat (3) tick(1'b0, 32'h0000_0000);
    axr(8'h08); `CHK("below thr", 32'h00FF_0000, rd)
    fill(1, 255);
    repeat (3) @(posedge aclk);
    axr(8'h08); `CHK("at thr", 32'h0100_0002, rd)
    for (int i = 0; i < 256; i++) tick(1'b1, base + 32'(i));
    tick(1'b0, 32'h0000_0000);
    `CHK("panel count", 256, n_words)
    `CHK("panel last", base + 32'h0000_00FF, last_word)
    repeat (3) @(posedge aclk);
    `CHK("irq up", 1'b1, irq)
    axr(8'h08); `CHK("flag", 32'h0000_0001, rd)
    axr(8'h0C); `CHK("irq status", 32'h0000_0001, rd)
    axw(8'h14, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'b0, irq)
    axw(8'h08, 32'h0000_0001);
    axr(8'h08); `CHK("flag w1c", 32'h0000_0000, rd)
    // Flag seen: software resets the controller.
    @(posedge aclk) rst_ctl <= 1;
    repeat (6) @(posedge aclk);
    rst_ctl <= 0;
    repeat (6) @(posedge aclk);
    axr(8'h00); `CHK("ctrl cleared", 32'h0000_0000, rd)
    axr(8'h04); `CHK("thr cleared", 32'h0000_0008, rd)
    // Start-up with a clock-enable stall and the underflow interrupt masked.
    axw(8'h10, 32'h0000_0001);
    axw(8'h00, 32'h0000_0002);
    fill(8, 300);
    @(posedge aclk) ce <= 0;
    repeat (3) @(posedge aclk);
    ce <= 1;
    for (int i = 0; i < 8; i++) tick(1'b1, base + 32'(300 + i));
    tick(1'b0, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    axr(8'h08); `CHK("stall flag", 32'h0000_0001, rd)
    axr(8'h0C); `CHK("masked status", 32'h0000_0000, rd)
    `CHK("irq masked", 1'b0, irq)
    conclude();
  end
endmodule : tb_raster_fifo_underflow

`default_nettype wire
